// [core/rpms_cfg.svh]
// offsets, field positions, reset values and timing counts of the power mode sequencer
`ifndef RPMS_CFG_SVH
`define RPMS_CFG_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define RPMS_ADDR_CTRL     8'h00
`define RPMS_ADDR_REGC     8'h0b
`define RPMS_ADDR_STAT     8'h10

// ----------------------------------------------------------------
// chip power mode control fields
// ----------------------------------------------------------------
`define RPMS_BIT_STANDBY   7
`define RPMS_BIT_RF_OUT    5
`define RPMS_BIT_HALF_PWR  4
`define RPMS_BIT_RX_SWAP   3
`define RPMS_BIT_AGC_ON    2
`define RPMS_BIT_RX_ON     1
`define RPMS_BIT_SUPPLY_5V 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RPMS_CTRL_RST      8'h01
`define RPMS_REGC_RST      8'h87

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RPMS_CLK_MHZ       40
`define RPMS_AUX_KHZ       60
`define RPMS_CONF_US       100
`define RPMS_REC_SBY_US    100
`define RPMS_REC_M1_US     25
`define RPMS_TMR_W         12
`define RPMS_AUX_W         9
`define RPMS_CONF_CYC      (`RPMS_CONF_US * `RPMS_CLK_MHZ)
`define RPMS_REC_SBY_CYC   (`RPMS_REC_SBY_US * `RPMS_CLK_MHZ)
`define RPMS_REC_M1_CYC    (`RPMS_REC_M1_US * `RPMS_CLK_MHZ)
`define RPMS_AUX_HALF_CYC  ((`RPMS_CLK_MHZ * 1000) / (2 * `RPMS_AUX_KHZ))

`endif

// [core/rpms_pkg.sv]
// types of the power mode sequencer
`default_nettype none
package rpms_pkg;
   typedef enum logic [2:0] {
      st_pd,
      st_sleep,
      st_start_en,
      st_start_wake,
      st_confirm,
      st_active
   } rpms_state_t;
endpackage
`default_nettype wire

// [core/rpms_tmr_if.sv]
// carrier between the sequencer and its countdown timers
`timescale 1ns/10ps
`default_nettype none
`include "rpms_cfg.svh"
interface rpms_tmr_if;
   logic                   start;
   logic [`RPMS_TMR_W-1:0] load;
   logic                   busy;
   logic                   expired;
   modport ctl (output start, output load, input busy, input expired);
   modport tmr (input start, input load, output busy, output expired);
endinterface
`default_nettype wire

// [core/rpms_timer.sv]
// one-shot countdown timer with expiry pulse
`timescale 1ns/10ps
`default_nettype none
`include "rpms_cfg.svh"
module rpms_timer
   import rpms_pkg::*;
(
   // clock and reset
   input  wire logic clk_in,
   input  wire logic nrst_in,
   input  wire logic ce_in,
   // timer carrier
   rpms_tmr_if.tmr   t
);
   logic [`RPMS_TMR_W-1:0] count;
   logic [`RPMS_TMR_W-1:0] next_count;
   logic                   exp_q;
   logic                   next_exp;

   always_comb begin
      next_count = count;
      next_exp   = 1'b0;
      if (t.start) begin
         next_count = t.load;
      end else if (count != '0) begin
         next_count = count - 1'b1;
         next_exp   = (count == `RPMS_TMR_W'(1));
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         count <= '0;
         exp_q <= 1'b0;
      end else if (ce_in) begin
         count <= next_count;
         exp_q <= next_exp;
      end
   end

   assign t.busy    = (count != '0);
   assign t.expired = exp_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_tmr_expiry: assert property (@(posedge clk_in) disable iff (!nrst_in) // R5
      ce_in && !t.start && count == `RPMS_TMR_W'(1) |=> t.expired && !t.busy)
      else $error("timer did not expire after its last count");
   a_tmr_steps: assert property (@(posedge clk_in) disable iff (!nrst_in) // R9
      ce_in && !t.start && t.busy |=> count == $past(count) - 1'b1)
      else $error("timer did not count down by one");
endmodule // rpms_timer
`default_nettype wire

// [core/rpms_clkdiv.sv]
// divider making the slow auxiliary clock from the core clock
`timescale 1ns/10ps
`default_nettype none
`include "rpms_cfg.svh"
module rpms_clkdiv
   import rpms_pkg::*;
(
   // clock and reset
   input  wire logic clk_in,
   input  wire logic nrst_in,
   input  wire logic ce_in,
   // control and clock out
   input  wire logic run_in,
   output logic      aux_clk_out
);
   logic [`RPMS_AUX_W-1:0] cnt;
   logic [`RPMS_AUX_W-1:0] next_cnt;
   logic                   next_aux;

   // half period rounds down, so the clock runs slightly fast
   always_comb begin
      next_cnt = cnt + 1'b1;
      next_aux = aux_clk_out;
      if (!run_in) begin
         next_cnt = '0;
         next_aux = 1'b0;
      end else if (cnt == `RPMS_AUX_W'(`RPMS_AUX_HALF_CYC - 1)) begin
         next_cnt = '0;
         next_aux = ~aux_clk_out;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt         <= '0;
         aux_clk_out <= 1'b0;
      end else if (ce_in) begin
         cnt         <= next_cnt;
         aux_clk_out <= next_aux;
      end
   end
endmodule // rpms_clkdiv
`default_nettype wire

// [core/rpms_top.sv]
// power mode sequencer of the reader front end
// Operation
// R1: main enable high runs all regulators, oscillator and fast clock output.
// R2: sleep keeps auxiliary supply and slow clock; transmitter, receiver, fast clock off.
// R3: wake enable rising from power-down starts regulators and oscillator.
// R4: once settled and stable, clock output switches from slow to fast clock.
// R5: after wake start, main enable must rise within 100 us, else power-down.
// R6: controller leaves 5 ms between changing main enable and wake enable.
// R7: controller must not raise both enables together at start-up.
// R8: with main enable high, power mode comes from control register bits.
// R9: standby turns transmitter and receiver off, clock kept; recovery 100 us.
// R10: mode 1 disables transmitter and receiver, clock kept; recovery 25 us.
// R11: mode 2 enables only the receiver for external field measurement.
// R12: RF output enable bit turns on transmitter and receiver.
// R13: power select bit selects half output power instead of full.
// R14: bit 0 selects 5 V or 3 V supply; 5 V is default.
// R15: entering power-down returns all mode bits to their defaults.
`timescale 1ns/10ps
`default_nettype none
`include "rpms_cfg.svh"
module rpms_top
   import rpms_pkg::*;
(
   // clock, reset, enable
   input  wire logic       core_clk_in,
   input  wire logic       nrst_in,
   input  wire logic       ce_in,
   // enable pins
   input  wire logic       main_enable_in,
   input  wire logic       wake_enable_pin_in,
   // analog status
   input  wire logic       regulators_settled_in,
   input  wire logic       osc_stable_in,
   input  wire logic       hf_osc_in,
   // register port
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   output logic      [7:0] reg_rdata_out,
   // power controls
   output logic            reg_enable_out,
   output logic            aux_supply_out,
   output logic            osc_run_out,
   output logic            tx_enable_out,
   output logic            rx_enable_out,
   output logic            half_power_out,
   output logic            supply_5v_out,
   output logic            rx_swap_out,
   output logic            agc_on_out,
   output logic      [7:0] regulator_cfg_out,
   // clock output and status
   output logic            mcu_clock_output_out,
   output logic            hf_clock_sel_out,
   output logic            ready_out,
   output logic      [2:0] power_state_out
);
   localparam int CONF_CYC = `RPMS_CONF_CYC;
   localparam int REC_CYC  = `RPMS_REC_SBY_CYC;

   rpms_state_t state;
   rpms_state_t next_state;
   logic        wake_prev;
   logic        wake_rise;
   logic        settled;
   logic [7:0]  ctrl;
   logic [7:0]  next_ctrl;
   logic [7:0]  regc;
   logic [7:0]  next_regc;
   logic [7:0]  next_rdata;
   logic        ctrl_wr;
   logic        regc_wr;
   logic        is_standby;
   logic        tx_mode;
   logic        rx_mode;
   logic        mode1;
   logic        new_standby;
   logic        new_active_rf;
   logic        hf_sel;
   logic        aux_run;
   logic        aux_clk;
   logic        next_reg_en;
   logic        next_tx;
   logic        next_rx;
   logic        next_ready;
   logic        next_mclk;

   rpms_tmr_if conf_t ();
   rpms_tmr_if rec_t ();

   rpms_timer u_conf_tmr (
      .clk_in  (core_clk_in),
      .nrst_in (nrst_in),
      .ce_in   (ce_in),
      .t       (conf_t)
   );

   rpms_timer u_rec_tmr (
      .clk_in  (core_clk_in),
      .nrst_in (nrst_in),
      .ce_in   (ce_in),
      .t       (rec_t)
   );

   rpms_clkdiv u_aux_div (
      .clk_in      (core_clk_in),
      .nrst_in     (nrst_in),
      .ce_in       (ce_in),
      .run_in      (aux_run),
      .aux_clk_out (aux_clk)
   );

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   assign wake_rise     = wake_enable_pin_in && !wake_prev;
   assign settled       = regulators_settled_in && osc_stable_in;
   assign ctrl_wr       = reg_wr_in && (reg_addr_in == `RPMS_ADDR_CTRL) && (state != st_pd);
   assign regc_wr       = reg_wr_in && (reg_addr_in == `RPMS_ADDR_REGC) && (state != st_pd);
   // R8: mode from bits
   assign is_standby    = ctrl[`RPMS_BIT_STANDBY];
   assign tx_mode       = !is_standby && ctrl[`RPMS_BIT_RF_OUT];
   assign rx_mode       = !is_standby && (ctrl[`RPMS_BIT_RF_OUT] || ctrl[`RPMS_BIT_RX_ON]);
   assign mode1         = !is_standby && !ctrl[`RPMS_BIT_RF_OUT] && !ctrl[`RPMS_BIT_RX_ON];
   assign new_standby   = reg_wdata_in[`RPMS_BIT_STANDBY];
   assign new_active_rf = reg_wdata_in[`RPMS_BIT_RF_OUT] || reg_wdata_in[`RPMS_BIT_RX_ON];
   assign hf_sel        = (state == st_confirm) || (state == st_active);
   assign aux_run       = (state == st_sleep) || (state == st_start_en)
                          || (state == st_start_wake);

   // ----------------------------------------------------------------
   // power state machine
   // ----------------------------------------------------------------
   // R7: main enable wins when both enables rise together
   always_comb begin
      next_state = state;
      unique case (state)
         st_pd: begin
            if (main_enable_in) begin
               next_state = st_start_en;
            // R3: wake edge starts up
            end else if (wake_rise) begin
               next_state = st_start_wake;
            end else if (wake_enable_pin_in) begin
               next_state = st_sleep;
            end
         end
         st_sleep: begin
            if (main_enable_in) begin
               next_state = st_start_en;
            end else if (!wake_enable_pin_in) begin
               next_state = st_pd;
            end
         end
         st_start_en: begin
            if (!main_enable_in) begin
               next_state = st_pd;
            end else if (settled) begin
               next_state = st_active;
            end
         end
         st_start_wake: begin
            // R4: switch clock once settled
            if (main_enable_in) begin
               next_state = st_start_en;
            end else if (settled) begin
               next_state = st_confirm;
            end
         end
         st_confirm: begin
            // R5: confirm or fall back
            if (main_enable_in) begin
               next_state = st_active;
            end else if (conf_t.expired) begin
               next_state = st_pd;
            end
         end
         st_active: begin
            if (!main_enable_in) begin
               next_state = st_pd;
            end
         end
         default: next_state = st_pd;
      endcase
   end

   // R5: window opens at the switchover
   assign conf_t.start = (state == st_start_wake) && !main_enable_in && settled;
   assign conf_t.load  = `RPMS_TMR_W'(`RPMS_CONF_CYC);

   // R9: standby exit waits for recovery
   // R10: mode 1 exit waits for recovery
   assign rec_t.start  = ctrl_wr && (state == st_active)
                         && ((is_standby && !new_standby) || (mode1 && !new_standby && new_active_rf));
   assign rec_t.load   = is_standby ? `RPMS_TMR_W'(`RPMS_REC_SBY_CYC)
                                    : `RPMS_TMR_W'(`RPMS_REC_M1_CYC);

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state     <= st_pd;
         wake_prev <= 1'b0;
      end else if (ce_in) begin
         state     <= next_state;
         wake_prev <= wake_enable_pin_in;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_comb begin
      next_ctrl  = ctrl;
      next_regc  = regc;
      next_rdata = 8'h00;
      if (ctrl_wr) begin
         next_ctrl = reg_wdata_in;
      end
      if (regc_wr) begin
         next_regc = reg_wdata_in;
      end
      // R15: defaults on power-down
      if (next_state == st_pd) begin
         next_ctrl = `RPMS_CTRL_RST;
         next_regc = `RPMS_REGC_RST;
      end
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            `RPMS_ADDR_CTRL: next_rdata = ctrl;
            `RPMS_ADDR_REGC: next_rdata = regc;
            `RPMS_ADDR_STAT: next_rdata = {4'h0, rec_t.busy, 3'(state)};
            default:         next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ctrl          <= `RPMS_CTRL_RST;
         regc          <= `RPMS_REGC_RST;
         reg_rdata_out <= 8'h00;
      end else if (ce_in) begin
         ctrl          <= next_ctrl;
         regc          <= next_regc;
         reg_rdata_out <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // power and clock outputs
   // ----------------------------------------------------------------
   always_comb begin
      // R1: regulators and oscillator while up
      next_reg_en = (state == st_start_en) || (state == st_start_wake) || hf_sel;
      // R12: transmitter with RF output
      // R11: receiver alone in mode 2
      // R9: standby keeps both off
      next_tx     = (state == st_active) && !rec_t.busy && tx_mode;
      next_rx     = (state == st_active) && !rec_t.busy && rx_mode;
      next_ready  = (state == st_active) && !rec_t.busy;
      // R2: slow clock until the fast one is chosen
      // R4: fast clock after switchover
      next_mclk   = hf_sel ? hf_osc_in : aux_clk;
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         reg_enable_out       <= 1'b0;
         aux_supply_out       <= 1'b0;
         osc_run_out          <= 1'b0;
         tx_enable_out        <= 1'b0;
         rx_enable_out        <= 1'b0;
         half_power_out       <= 1'b0;
         supply_5v_out        <= 1'b1;
         rx_swap_out          <= 1'b0;
         agc_on_out           <= 1'b0;
         regulator_cfg_out    <= `RPMS_REGC_RST;
         mcu_clock_output_out <= 1'b0;
         hf_clock_sel_out     <= 1'b0;
         ready_out            <= 1'b0;
      end else if (ce_in) begin
         reg_enable_out       <= next_reg_en;
         // R2: auxiliary supply outside power-down
         aux_supply_out       <= (state != st_pd);
         osc_run_out          <= next_reg_en;
         tx_enable_out        <= next_tx;
         rx_enable_out        <= next_rx;
         // R13: half power select
         half_power_out       <= next_tx && ctrl[`RPMS_BIT_HALF_PWR];
         // R14: supply range select
         supply_5v_out        <= ctrl[`RPMS_BIT_SUPPLY_5V];
         rx_swap_out          <= ctrl[`RPMS_BIT_RX_SWAP];
         agc_on_out           <= ctrl[`RPMS_BIT_AGC_ON];
         regulator_cfg_out    <= regc;
         mcu_clock_output_out <= next_mclk;
         hf_clock_sel_out     <= hf_sel;
         ready_out            <= next_ready;
      end
   end

   assign power_state_out = state;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [12:0] conf_cnt;
   logic [12:0] rec_cnt;

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         conf_cnt <= '0;
         rec_cnt  <= '0;
      end else if (ce_in) begin
         conf_cnt <= (state == st_confirm) ? conf_cnt + 1'b1 : 13'h0000;
         rec_cnt  <= rec_t.busy ? rec_cnt + 1'b1 : 13'h0000;
      end
   end

   a_run_all_on: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // R1
      ce_in && state == st_active |=> reg_enable_out && osc_run_out && hf_clock_sel_out)
      else $error("active state without regulators, oscillator or fast clock");
   a_sleep_outputs: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // R2
      ce_in && state == st_sleep |=> aux_supply_out && !tx_enable_out && !rx_enable_out
      && !hf_clock_sel_out)
      else $error("sleep outputs wrong");
   a_wake_start: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // R3
      ce_in && state == st_pd && wake_rise && !main_enable_in
      |=> state == st_start_wake ##1 (!ce_in || reg_enable_out))
      else $error("wake edge did not start regulators");
   a_clock_switch: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // R4
      ce_in && state == st_start_wake && settled && !main_enable_in
      |=> state == st_confirm ##1 (!ce_in || hf_clock_sel_out))
      else $error("clock did not switch after settling");
   a_confirm_lapse: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // R5
      ce_in && state == st_confirm && conf_t.expired && !main_enable_in |=> state == st_pd)
      else $error("unconfirmed wake did not return to power-down");
   a_confirm_bound: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // R5
      conf_cnt <= 13'(CONF_CYC + 2))
      else $error("confirm window too long");
   a_standby_off: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // R9
      ce_in && state == st_active && is_standby
      |=> !tx_enable_out && !rx_enable_out && hf_clock_sel_out)
      else $error("standby left RF on");
   a_recover_bound: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // R9
      rec_cnt <= 13'(REC_CYC))
      else $error("recovery too long");
   a_mode1_off: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // R10
      ce_in && state == st_active && mode1 |=> !tx_enable_out && !rx_enable_out)
      else $error("mode 1 left RF on");
   a_rx_only: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // R11
      ce_in && state == st_active && !rec_t.busy && rx_mode && !tx_mode
      |=> rx_enable_out && !tx_enable_out)
      else $error("mode 2 wrong");
   a_tx_rx_on: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // R12
      ce_in && state == st_active && !rec_t.busy && tx_mode |=> tx_enable_out && rx_enable_out)
      else $error("RF output mode did not enable RF");
   a_half_power: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // R13
      ce_in && state == st_active && !rec_t.busy && tx_mode
      |=> half_power_out == $past(ctrl[`RPMS_BIT_HALF_PWR]))
      else $error("half power does not follow its select bit");
   a_pd_defaults: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // R15
      ce_in && state == st_active && !main_enable_in
      |=> ctrl == `RPMS_CTRL_RST ##1 (!ce_in || supply_5v_out))
      else $error("power-down kept mode bits");

   c_wake_confirm: cover property (@(posedge core_clk_in) disable iff (!nrst_in)
      state == st_confirm ##1 state == st_active);
   c_wake_lapse: cover property (@(posedge core_clk_in) disable iff (!nrst_in)
      state == st_confirm ##1 state == st_pd);
   c_standby_exit: cover property (@(posedge core_clk_in) disable iff (!nrst_in)
      rec_t.start && is_standby);
endmodule // rpms_top
`default_nettype wire

// [test/rpms_analog_model.sv]
// model of the supplies and crystal oscillator behind the sequencer
`timescale 1ns/10ps
`default_nettype none
module rpms_analog_model #(parameter int SETTLE = 20) (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic nrst_in,
   // start request from the sequencer
   input  wire logic run_in,
   // analog status back
   output logic      settled_out,
   output logic      stable_out,
   output var logic  hf_osc_out
);
   int cnt;
   // supplies settle before the crystal is stable
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt <= 0;
         hf_osc_out <= 1'b0;
      end else begin
         cnt <= run_in ? (cnt < SETTLE ? cnt + 1 : cnt) : 0;
         hf_osc_out <= run_in & ~hf_osc_out;
      end
   end
   assign settled_out = run_in && cnt >= SETTLE / 2;
   assign stable_out  = run_in && cnt >= SETTLE;
endmodule // rpms_analog_model
`default_nettype wire

// [test/tb_reader_power_mode_sequencer.sv]
// self-checking bench of the power mode sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_reader_power_mode_sequencer;
   import rpms_pkg::*;
   logic       clk = 0, nrst = 0, main = 0, wake = 0, wr = 0, rd = 0, pend = 0, ce = 1;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, r, rcfg;
   logic       s5v, swp, agc, mclk;
   logic       reg_en, aux, osc, tx, rx, half, hsel, rdy, settled, stable, hf;
   logic [2:0] st;
   logic [7:0] exp_q[$];
   int         error_cnt = 0, num_checks = 0;
   always #12.5 clk = ~clk;
   rpms_analog_model i_ana (.clk_in(clk), .nrst_in(nrst), .run_in(osc),
      .settled_out(settled), .stable_out(stable), .hf_osc_out(hf));
   rpms_top i_dut (.core_clk_in(clk), .nrst_in(nrst), .ce_in(ce),
      .main_enable_in(main), .wake_enable_pin_in(wake), .regulators_settled_in(settled),
      .osc_stable_in(stable), .hf_osc_in(hf), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_enable_out(reg_en),
      .aux_supply_out(aux), .osc_run_out(osc), .tx_enable_out(tx), .rx_enable_out(rx),
      .half_power_out(half), .supply_5v_out(s5v), .rx_swap_out(swp), .agc_on_out(agc),
      .regulator_cfg_out(rcfg), .mcu_clock_output_out(mclk), .hf_clock_sel_out(hsel),
      .ready_out(rdy), .power_state_out(st));
   task automatic chk_level(string n, logic [7:0] e, logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_read(logic [7:0] e, logic [7:0] g);
      chk_level("read data", e, g);
   endtask
   task automatic wreg(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(logic [7:0] a, logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task automatic wait_st(logic [2:0] s, int lim);
      for (int i = 0; i < lim && st !== s; i++) @(negedge clk);
      chk_level("state", {5'h0, s}, {5'h0, st});
   endtask
   task automatic print_verdict;
      if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // read data stands only in the cycle after the strobe
   always @(negedge clk) begin
      if (pend && exp_q.size() > 0) chk_read(exp_q.pop_front(), rdata);
      pend = rd;
   end
   // a hang costs one mismatch, then the usual verdict
   initial begin
      #(25 * 30000);
      error_cnt++;
      print_verdict();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      r = 8'($urandom(38194));
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      rreg(8'h00, 8'h01);
      rreg(8'h0b, 8'h87);
      // main enable alone, wake kept low
      @(posedge clk);
      main <= 1'b1;
      wait_st(3'd5, 200);
      @(negedge clk);
      chk_level("supplies", 8'h03, {6'h0, reg_en, osc});
      chk_level("fast clock", 8'h01, {7'h0, hsel});
      @(negedge clk);
      chk_level("fast clock out", {7'h0, ~hf}, {7'h0, mclk});
      wreg(8'h21, 8'h00);
      wreg(8'h00, 8'h21);
      repeat (900) @(negedge clk);
      chk_level("mode1 recovery", 8'h00, {6'h0, tx, rdy});
      repeat (105) @(negedge clk);
      chk_level("full power", 8'h06, {5'h0, tx, rx, half});
      wreg(8'h00, 8'h31);
      repeat (3) @(negedge clk);
      chk_level("half power", 8'h07, {5'h0, tx, rx, half});
      wreg(8'h00, 8'h03);
      repeat (3) @(negedge clk);
      chk_level("rx only", 8'h02, {5'h0, tx, rx, half});
      wreg(8'h00, 8'h0c);
      repeat (3) @(negedge clk);
      chk_level("swap agc 3v", 8'h18, {3'h0, swp, agc, s5v, tx, rx});
      wreg(8'h00, 8'h81);
      repeat (3) @(negedge clk);
      chk_level("standby", 8'h01, {5'h0, tx, rx, hsel});
      wreg(8'h00, 8'h21);
      repeat (4005) @(negedge clk);
      chk_level("standby recovery", 8'h03, {6'h0, tx, rx});
      rreg(8'h00, 8'h21);
      r = 8'($urandom);
      wreg(8'h0b, r);
      rreg(8'h0b, r);
      @(negedge clk);
      chk_level("regulator cfg", r, rcfg);
      wreg(8'h10, 8'hff);
      rreg(8'h10, 8'h05);
      rreg(8'h20, 8'h00);
      @(posedge clk);
      main <= 1'b0;
      wait_st(3'd0, 10);
      rreg(8'h00, 8'h01);
      rreg(8'h0b, 8'h87);
      // one pin moves at a time; the block does not time the gap
      @(posedge clk);
      wake <= 1'b1;
      wait_st(3'd3, 5);
      wait_st(3'd4, 100);
      @(negedge clk);
      @(negedge clk);
      chk_level("switchover", 8'h03, {6'h0, hsel, reg_en});
      wait_st(3'd0, 4100);
      wait_st(3'd1, 5);
      @(negedge clk);
      chk_level("sleep", 8'h10, {3'h0, aux, tx, rx, hsel, mclk});
      repeat (340) @(negedge clk);
      chk_level("slow clock", 8'h01, {7'h0, mclk});
      @(posedge clk);
      main <= 1'b1;
      wait_st(3'd5, 200);
      // freeze: a dropped main enable waits for the clock enable
      @(posedge clk);
      ce <= 1'b0;
      main <= 1'b0;
      repeat (5) @(negedge clk);
      chk_level("frozen", 8'h0d, {4'h0, reg_en, st});
      @(posedge clk);
      ce <= 1'b1;
      wait_st(3'd0, 5);
      print_verdict();
   end
endmodule // tb_reader_power_mode_sequencer
`default_nettype wire
